// file: verilog/timer_map.svh
// timer pin-function and flag block: register offsets, field positions, reset values
// assumes an 8-bit register port with a 5-bit word address
//
// Notes on behaviour
// - Timer pins stay plain I/O until a timer function using them is enabled.
// - Function select 0 gives input capture, 1 gives output compare.
// - Pin edges capture on input pins, latch edges on output pins; capture never forces direction.
// - Timer disabled: direction 0 input, direction 1 driven from port latch.
// - Capture channel with zero edge field: no capture, plain digital pin.
// - Capture channel set as output: latch drives pin, its edges still capture.
// - Compare channel with mode or level set: pin driven by compare action.
// - Compare override keeps stored direction; latch then does not drive pin.
// - Compare with mode and level clear: flags still set, pin stays plain.
// - Port read gives pin level if direction 0, latch if direction 1.
// - Channel-3 mask bit forces compare-channel pin to output, direction kept.
// - Channel-3 mask bit never forces capture-channel pins; it still gates their latch copy.
// - Channel-3 compare drives masked compare pins with channel-3 data bits.
// - Channel-3 compare copies masked channel-3 data bits into port latch.
// - Seven flags each raise an interrupt request when their enable is set.
// - Channel flag sets on capture or compare; cleared by writing 1 only.
// - Fast clear: capture value read or compare value write clears flag.
// - A set channel flag never blocks later captures or compares.
// - Accumulator overflow flag sets on wrap, clears on writing 1.
// - Fast clear: any accumulator count access clears both accumulator flags.
// - Counter overflow flag sets on counter wrap, clears on writing 1.
// - Accumulator input flag: active edge, or trailing gate edge when gated.
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_SYS_CTL 5'h00
`define OFS_FUNC_SEL 5'h01
`define OFS_OUT_ACT 5'h02
`define OFS_EDGE_CTL 5'h03
`define OFS_CH3_MASK 5'h04
`define OFS_CH3_DATA 5'h05
`define OFS_PORT_DATA 5'h06
`define OFS_PORT_DIR 5'h07
`define OFS_CHAN_FLAG 5'h08
`define OFS_CHAN_IRQ 5'h09
`define OFS_ACC_FLAG 5'h0A
`define OFS_ACC_CTL 5'h0B
`define OFS_CNT_FLAG 5'h0C
`define OFS_CNT_IRQ 5'h0D
`define OFS_VALUE0 5'h10
`define OFS_ACC_CNT_HI 5'h18
`define OFS_ACC_CNT_LO 5'h19
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define BIT_ENABLE 0
`define BIT_FAST_CLR 1
`define BIT_ACC_OVF 0
`define BIT_ACC_IN 1
`define BIT_ACC_MODE 2
`define BIT_ACC_POL 3
`define RST_BYTE 8'h00
`define RST_NIBBLE 4'h0
`endif

// file: verilog/timer_pkg.sv
// types shared by the timer pin-function block
// assumes nothing beyond the compiler
package timer_pkg;
  typedef enum logic [1:0] {act_off, act_toggle, act_clear, act_set} oc_action_e;
  typedef enum logic [1:0] {edge_off, edge_rise, edge_fall, edge_any} edge_sel_e;
endpackage

// file: verilog/pin_sync.sv
// three-stage input synchroniser with agreement filter
// assumes asynchronous inputs and an active-high asynchronous reset
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk, // module clock
  input wire logic reset, // async reset
  input wire logic [WIDTH-1:0] din, // raw pin levels
  output logic [WIDTH-1:0] dout // filtered levels
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_dout;

  // a change counts only once stages two and three agree
  assign next_dout = (stage2 & stage3) | (dout & (stage2 | stage3));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      dout <= next_dout;
    end
  end
endmodule // pin_sync

// file: verilog/channel_pin.sv
// one timer channel: compare output level and pin drive selection
// assumes compare strobes already gated by enable and function select
module channel_pin import timer_pkg::*; (
  input wire logic clk, // module clock
  input wire logic reset, // async reset
  input wire logic enable, // timer enabled
  input wire logic oc_sel, // channel in output compare
  input wire logic [1:0] action, // mode and level pair
  input wire logic mask, // channel-3 mask bit
  input wire logic dir, // stored direction bit
  input wire logic latch, // port data latch bit
  input wire logic compare, // compare event on this channel
  input wire logic ch3_hit, // compare event on channel 3
  input wire logic ch3_bit, // channel-3 data bit
  output logic pin_out, // pin output value
  output logic pin_oe_n // low while pin is driven
);
  logic level;
  logic next_level;
  logic oc_drive;
  logic override;

  // mask only matters in compare mode; direction bit itself is never touched
  assign oc_drive = enable & oc_sel & ((action != act_off) | mask);
  assign override = ch3_hit & enable & oc_sel & mask;
  assign pin_out = oc_drive ? level : latch;
  assign pin_oe_n = ~(oc_drive | dir);

  always_comb begin
    next_level = level;
    if (override) begin
      next_level = ch3_bit;
    end else if (compare) begin
      case (oc_action_e'(action))
        act_toggle: next_level = ~level;
        act_clear: next_level = 1'b0;
        act_set: next_level = 1'b1;
        default: next_level = level;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level <= 1'b0;
    end else begin
      level <= next_level;
    end
  end
endmodule // channel_pin

// file: verilog/timer_pins.sv
// timer pin-function selection, event flags and interrupt requests
// assumes counter and accumulator logic elsewhere supply match and wrap strobes
//
// Added by the designer: the register offsets and the strobed register port.
`include "timer_map.svh"
module timer_pins import timer_pkg::*; (
  input wire logic clk, // module clock, 100 MHz
  input wire logic reset, // async reset, active high
  input wire logic [4:0] addr, // register word address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  input wire logic [3:0] pin_in, // timer_port_pin levels
  output logic [3:0] pin_out, // timer_port_pin drive values
  output logic [3:0] pin_oe_n, // low while a pin is driven
  input wire logic [3:0] compare_match, // counter equals channel value
  input wire logic counter_wrap, // counter rolled to zero
  input wire logic accum_wrap, // accumulator rolled to zero
  output logic [3:0] capture_strobe, // latch counter into channel value
  output logic accum_event, // count one accumulator edge
  output logic accum_gate, // gated divide-by-64 count enable
  output logic timer_enable, // timer_enable_bit
  output logic ch3_compare, // channel-3 compare event
  output logic [6:0] irq // interrupt requests
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic timer_enable_bit;
  logic fast_flag_clear;
  logic [3:0] capture_compare_select_reg;
  logic [7:0] output_action_control;
  logic [7:0] edge_control;
  logic [3:0] ch3_mask_bit;
  logic [3:0] ch3_data_bit;
  logic [3:0] port_latch;
  logic [3:0] port_direction_reg;
  logic [3:0] channel_flag;
  logic [3:0] channel_irq_enable;
  logic accum_overflow_flag;
  logic accum_input_flag;
  logic [3:0] accum_control_reg;
  logic counter_overflow_flag;
  logic counter_overflow_irq_enable;
  logic [3:0] cap_prev;
  logic accum_prev;
  logic [7:0] next_rdata;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    case (edge_sel_e'(sel))
      edge_rise: edge_hit = cur & ~prev;
      edge_fall: edge_hit = prev & ~cur;
      edge_any: edge_hit = cur ^ prev;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  wire wr_sys = wr && addr == `OFS_SYS_CTL;
  wire wr_func = wr && addr == `OFS_FUNC_SEL;
  wire wr_act = wr && addr == `OFS_OUT_ACT;
  wire wr_edge = wr && addr == `OFS_EDGE_CTL;
  wire wr_mask = wr && addr == `OFS_CH3_MASK;
  wire wr_data3 = wr && addr == `OFS_CH3_DATA;
  wire wr_port = wr && addr == `OFS_PORT_DATA;
  wire wr_dir = wr && addr == `OFS_PORT_DIR;
  wire wr_cflag = wr && addr == `OFS_CHAN_FLAG;
  wire wr_cirq = wr && addr == `OFS_CHAN_IRQ;
  wire wr_aflag = wr && addr == `OFS_ACC_FLAG;
  wire wr_actl = wr && addr == `OFS_ACC_CTL;
  wire wr_tflag = wr && addr == `OFS_CNT_FLAG;
  wire wr_tirq = wr && addr == `OFS_CNT_IRQ;
  wire acc_cnt_hit = addr == `OFS_ACC_CNT_HI || addr == `OFS_ACC_CNT_LO;
  wire acc_access = fast_flag_clear && (rd || wr) && acc_cnt_hit;
  wire [3:0] pin_level;
  wire [3:0] cap_src;
  wire [3:0] cmp_ev;
  wire [3:0] chan_set;
  wire [3:0] fast_clr;
  wire [3:0] chan_clr;
  wire [3:0] port_view;
  wire acc_pin = pin_level[3];
  wire acc_mode = accum_control_reg[`BIT_ACC_MODE];
  wire acc_pol = accum_control_reg[`BIT_ACC_POL];
  wire acc_in_set;
  wire acc_ovf_clr;
  wire acc_in_clr;
  wire cnt_clr;

  // ----------------------------------------
  // pin synchroniser and channels
  // ----------------------------------------
  pin_sync #(.WIDTH(4)) u_sync (
    .clk(clk),
    .reset(reset),
    .din(pin_in),
    .dout(pin_level)
  );

  // an output-configured capture pin captures its own latch value
  assign cap_src = (port_direction_reg & port_latch) | (~port_direction_reg & pin_level);
  assign port_view = cap_src;
  assign ch3_compare = cmp_ev[3];
  assign timer_enable = timer_enable_bit;

  genvar n;
  generate
    for (n = 0; n < 4; n++) begin : g_chan
      wire [1:0] ch_edge = edge_control[2*n+1:2*n];
      wire [4:0] val_ofs = `OFS_VALUE0 + 5'(n);
      // zero edge field gives no capture; set flags never block new events
      assign capture_strobe[n] = timer_enable_bit & ~capture_compare_select_reg[n]
        & edge_hit(ch_edge, cap_prev[n], cap_src[n]);
      assign cmp_ev[n] = timer_enable_bit & capture_compare_select_reg[n]
        & compare_match[n];
      assign fast_clr[n] = fast_flag_clear && addr == val_ofs
        && ((rd && !capture_compare_select_reg[n])
        || (wr && capture_compare_select_reg[n]));
      channel_pin u_pin (
        .clk(clk),
        .reset(reset),
        .enable(timer_enable_bit),
        .oc_sel(capture_compare_select_reg[n]),
        .action(output_action_control[2*n+1:2*n]),
        .mask(ch3_mask_bit[n]),
        .dir(port_direction_reg[n]),
        .latch(port_latch[n]),
        .compare(cmp_ev[n]),
        .ch3_hit(cmp_ev[3]),
        .ch3_bit(ch3_data_bit[n]),
        .pin_out(pin_out[n]),
        .pin_oe_n(pin_oe_n[n])
      );
    end
  endgenerate

  // ----------------------------------------
  // flags
  // ----------------------------------------
  assign chan_set = capture_strobe | cmp_ev;
  assign chan_clr = (wr_cflag ? wdata[3:0] : 4'h0) | fast_clr;

  // gated mode flags the trailing edge of the active level
  assign acc_in_set = edge_hit((acc_pol ^ acc_mode) ? edge_rise : edge_fall,
    accum_prev, acc_pin);
  assign accum_event = ~acc_mode & acc_in_set;
  // no divide-by-64 clock exists while the timer is off
  assign accum_gate = acc_mode & timer_enable_bit & ~(acc_pin ^ acc_pol);
  assign acc_ovf_clr = (wr_aflag & wdata[`BIT_ACC_OVF]) | acc_access;
  assign acc_in_clr = (wr_aflag & wdata[`BIT_ACC_IN]) | acc_access;
  assign cnt_clr = wr_tflag & wdata[0];

  assign irq = {counter_overflow_flag & counter_overflow_irq_enable,
    accum_input_flag & accum_control_reg[`BIT_ACC_IN],
    accum_overflow_flag & accum_control_reg[`BIT_ACC_OVF],
    channel_flag & channel_irq_enable};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      channel_flag <= `RST_NIBBLE;
      accum_overflow_flag <= 1'b0;
      accum_input_flag <= 1'b0;
      counter_overflow_flag <= 1'b0;
      cap_prev <= `RST_NIBBLE;
      accum_prev <= 1'b0;
    end else begin
      // a set in the same cycle as a clear wins
      channel_flag <= chan_set | (channel_flag & ~chan_clr);
      accum_overflow_flag <= accum_wrap | (accum_overflow_flag & ~acc_ovf_clr);
      accum_input_flag <= acc_in_set | (accum_input_flag & ~acc_in_clr);
      counter_overflow_flag <= counter_wrap | (counter_overflow_flag & ~cnt_clr);
      cap_prev <= cap_src;
      accum_prev <= acc_pin;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timer_enable_bit <= 1'b0;
      fast_flag_clear <= 1'b0;
      capture_compare_select_reg <= `RST_NIBBLE;
      output_action_control <= `RST_BYTE;
      edge_control <= `RST_BYTE;
      ch3_mask_bit <= `RST_NIBBLE;
      ch3_data_bit <= `RST_NIBBLE;
      port_direction_reg <= `RST_NIBBLE;
      channel_irq_enable <= `RST_NIBBLE;
      accum_control_reg <= `RST_NIBBLE;
      counter_overflow_irq_enable <= 1'b0;
    end else begin
      if (wr_sys) begin
        timer_enable_bit <= wdata[`BIT_ENABLE];
        fast_flag_clear <= wdata[`BIT_FAST_CLR];
      end
      if (wr_func) capture_compare_select_reg <= wdata[3:0];
      if (wr_act) output_action_control <= wdata;
      if (wr_edge) edge_control <= wdata;
      if (wr_mask) ch3_mask_bit <= wdata[3:0];
      if (wr_data3) ch3_data_bit <= wdata[3:0];
      if (wr_dir) port_direction_reg <= wdata[3:0];
      if (wr_cirq) channel_irq_enable <= wdata[3:0];
      if (wr_actl) accum_control_reg <= wdata[3:0];
      if (wr_tirq) counter_overflow_irq_enable <= wdata[0];
    end
  end

  // on masked bits, channel-3 compare copy beats a software write in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_latch <= `RST_NIBBLE;
    end else if (cmp_ev[3]) begin
      port_latch <= (ch3_mask_bit & ch3_data_bit)
        | (~ch3_mask_bit & (wr_port ? wdata[3:0] : port_latch));
    end else if (wr_port) begin
      port_latch <= wdata[3:0];
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb begin
    if (addr == `OFS_SYS_CTL) begin
      next_rdata = {6'h00, fast_flag_clear, timer_enable_bit};
    end else if (addr == `OFS_FUNC_SEL) begin
      next_rdata = {4'h0, capture_compare_select_reg};
    end else if (addr == `OFS_OUT_ACT) begin
      next_rdata = output_action_control;
    end else if (addr == `OFS_EDGE_CTL) begin
      next_rdata = edge_control;
    end else if (addr == `OFS_CH3_MASK) begin
      next_rdata = {4'h0, ch3_mask_bit};
    end else if (addr == `OFS_CH3_DATA) begin
      next_rdata = {4'h0, ch3_data_bit};
    end else if (addr == `OFS_PORT_DATA) begin
      next_rdata = {4'h0, port_view};
    end else if (addr == `OFS_PORT_DIR) begin
      next_rdata = {4'h0, port_direction_reg};
    end else if (addr == `OFS_CHAN_FLAG) begin
      next_rdata = {4'h0, channel_flag};
    end else if (addr == `OFS_CHAN_IRQ) begin
      next_rdata = {4'h0, channel_irq_enable};
    end else if (addr == `OFS_ACC_FLAG) begin
      next_rdata = {6'h00, accum_input_flag, accum_overflow_flag};
    end else if (addr == `OFS_ACC_CTL) begin
      next_rdata = {4'h0, accum_control_reg};
    end else if (addr == `OFS_CNT_FLAG) begin
      next_rdata = {7'h00, counter_overflow_flag};
    end else if (addr == `OFS_CNT_IRQ) begin
      next_rdata = {7'h00, counter_overflow_irq_enable};
    end else begin
      next_rdata = `RST_BYTE;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= `RST_BYTE;
    end else begin
      rdata <= rd ? next_rdata : `RST_BYTE;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  wire [3:0] oc_force;
  wire [3:0] edge_on;
  for (n = 0; n < 4; n++) begin : g_force
    assign oc_force[n] = timer_enable_bit & capture_compare_select_reg[n]
      & (output_action_control[2*n+1:2*n] != 2'b00 | ch3_mask_bit[n]);
    assign edge_on[n] = |edge_control[2*n+1:2*n];
  end

  a_flag_sets_event: assert property (|chan_set |=>
    (channel_flag & $past(chan_set)) == $past(chan_set))
    else $error("channel flag missed an event");
  a_flag_zero_write: assert property (wr_cflag && wdata[3:0] == 4'h0
    |=> channel_flag == ($past(channel_flag) | $past(chan_set)))
    else $error("zero write changed a channel flag");
  a_disabled_gpio: assert property (!timer_enable_bit |->
    pin_oe_n == ~port_direction_reg && pin_out == port_latch)
    else $error("disabled timer pin not plain I/O");
  a_oc_drives_pin: assert property ((oc_force & pin_oe_n) == 4'h0)
    else $error("compare pin not driven");
  a_ic_mask_inert: assert property (timer_enable_bit |->
    ((~pin_oe_n ^ port_direction_reg) & ~capture_compare_select_reg) == 4'h0)
    else $error("capture pin direction overridden");
  a_port_read: assert property (rd && addr == `OFS_PORT_DATA |=>
    rdata[3:0] == $past(port_view) && rdata[7:4] == 4'h0)
    else $error("port read value wrong");
  a_ch3_copy: assert property (cmp_ev[3] |=>
    (port_latch & $past(ch3_mask_bit)) == ($past(ch3_data_bit) & $past(ch3_mask_bit)))
    else $error("channel-3 data not copied");
  a_ffc_accum: assert property (acc_access && !accum_wrap && !acc_in_set
    |=> !accum_overflow_flag && !accum_input_flag)
    else $error("accumulator flags not cleared by count access");
  a_acc_ovf_irq: assert property (accum_wrap && accum_control_reg[`BIT_ACC_OVF] && !wr_actl
    |=> accum_overflow_flag && irq[4])
    else $error("accumulator overflow not requested");
  a_cnt_ovf_irq: assert property (counter_wrap && counter_overflow_irq_enable && !wr_tirq
    |=> ##[0:2] irq[6])
    else $error("counter overflow not requested");

  // invariants that hold whatever the pins and strobes do
  a_fast_clear_chan: assert property (|(fast_clr & ~chan_set) |=>
    (channel_flag & $past(fast_clr & ~chan_set)) == 4'h0)
    else $error("fast clear left a channel flag set");
  a_cap_edge_off: assert property ((capture_strobe & ~edge_on) == 4'h0)
    else $error("capture with edge field off");
  a_dir_kept: assert property (!wr_dir |=>
    port_direction_reg == $past(port_direction_reg))
    else $error("direction bits changed without a write");
  a_oc_off_plain: assert property (timer_enable_bit |->
    ((~pin_oe_n ^ port_direction_reg) & ~oc_force) == 4'h0)
    else $error("undriven pin ignores its direction bit");
  a_cnt_flag_clear: assert property (cnt_clr && !counter_wrap |=>
    !counter_overflow_flag)
    else $error("counter overflow flag not cleared");
  a_acc_flag_clear: assert property (wr_aflag && wdata[`BIT_ACC_OVF] && !accum_wrap |=>
    !accum_overflow_flag)
    else $error("accumulator overflow flag not cleared");
  a_irq_needs_flag: assert property ((irq[3:0] & ~channel_flag) == 4'h0)
    else $error("channel request without its flag");
  a_disabled_quiet: assert property (!timer_enable_bit |->
    capture_strobe == 4'h0 && cmp_ev == 4'h0)
    else $error("event while timer disabled");
  a_ch3_pin_data: assert property (cmp_ev[3] && !wr |=>
    ((pin_out ^ ch3_data_bit) & ch3_mask_bit & capture_compare_select_reg) == 4'h0)
    else $error("channel-3 data not on masked compare pin");
  a_ch3_latch_keep: assert property (cmp_ev[3] && !wr_port |=>
    (port_latch & ~$past(ch3_mask_bit)) == ($past(port_latch) & ~$past(ch3_mask_bit)))
    else $error("unmasked latch bit changed on channel-3 compare");

  c_capture: cover property (capture_strobe[0] ##1 channel_flag[0]);
  c_ch3_override: cover property (cmp_ev[3] && ch3_mask_bit != 4'h0);
  c_fast_clear: cover property (channel_flag[1] && fast_clr[1]);
  c_gated_trail: cover property (acc_mode && acc_in_set);
  c_any_edge: cover property (capture_strobe[0] && edge_control[1:0] == 2'b11);
endmodule // timer_pins

// file: verif/pin_partner.sv
// outside world on the four timer port pins
// assumes the bench sets ext_level; module drive wins where its enable is low
module pin_partner (
  input wire logic [3:0] pin_out, // module drive values
  input wire logic [3:0] pin_oe_n, // low while the module drives
  input wire logic [3:0] ext_level, // level applied from outside
  output logic [3:0] pin_in // resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------
  // wire resolution
  // ----------------
  // outside drivers back off where the module drives, so a driven pin reads its own value
  assign pin_in = (pin_oe_n & ext_level) | (~pin_oe_n & pin_out);
endmodule // pin_partner

// file: verif/timer_pin_function_and_flags_tb_top.sv
// self-checking bench for the timer pin-function and flag block
// assumes timer_pins and its map header; compare and wrap strobes come from here
`include "timer_map.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module timer_pin_function_and_flags_tb_top import timer_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, wr, rd, counter_wrap, accum_wrap, acc_event, acc_gate, tmr_en, ch3_cmp;
  logic [4:0] addr;
  logic [7:0] wdata, rdata;
  logic [3:0] pin_in, pin_out, pin_oe_n, compare_match, ext, cap_strobe;
  logic [6:0] irq;
  int n_fail;
  int samples_checked;
  int n_cap = 0;
  int n_evt = 0;
  int n_ch3 = 0;

  timer_pins uut (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .compare_match(compare_match),
    .counter_wrap(counter_wrap), .accum_wrap(accum_wrap), .capture_strobe(cap_strobe),
    .accum_event(acc_event), .accum_gate(acc_gate), .timer_enable(tmr_en),
    .ch3_compare(ch3_cmp), .irq(irq)
  );
  pin_partner far (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext), .pin_in(pin_in));
  // strobes last one cycle, so count them here and let scenarios check the totals
  always @(posedge clk) begin
    if (!reset && cap_strobe != 4'h0) n_cap <= n_cap + 1;
    if (!reset && acc_event) n_evt <= n_evt + 1;
    if (!reset && ch3_cmp) n_ch3 <= n_ch3 + 1;
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------
  // bus and strobe helpers
  // ----------------
  task automatic results();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk);
    reset <= 1'b1;
    ext <= 4'h0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic pulse(input logic [3:0] m, input logic cw, input logic aw);
    @(posedge clk);
    compare_match <= m;
    counter_wrap <= cw;
    accum_wrap <= aw;
    @(posedge clk);
    compare_match <= 4'h0;
    counter_wrap <= 1'b0;
    accum_wrap <= 1'b0;
    #1;
  endtask
  // bounded: a request that never comes ends the run as a failure
  task automatic wait_irq(input int i);
    int k;
    for (k = 0; k < 20 && irq[i] !== 1'b1; k++) @(posedge clk);
    if (k == 20) begin
      n_fail++;
      results();
    end
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_reset();
    do_reset();
    `CHK(pin_oe_n, 4'hF)
    `CHK(irq, 7'h00)
    for (int a = 0; a < 14; a++) begin
      rd_chk(5'(a), `RST_BYTE);
    end
    wr_reg(5'h1F, 8'hFF);
    rd_chk(5'h1F, 8'h00);
  endtask
  task automatic t_gpio();
    do_reset();
    ext <= 4'hA;
    wr_reg(`OFS_PORT_DIR, 8'h03);
    wr_reg(`OFS_PORT_DATA, 8'h05);
    `CHK(pin_oe_n, 4'hC)
    `CHK(pin_out[1:0], 2'b01)
    wr_reg(`OFS_EDGE_CTL, 8'h00);
    wr_reg(`OFS_SYS_CTL, 8'h01);
    `CHK(tmr_en, 1'b1)
    `CHK(pin_oe_n, 4'hC)
    @(posedge clk);
    ext <= 4'hE;
    repeat (8) @(posedge clk);
    rd_chk(`OFS_CHAN_FLAG, 8'h00);
    rd_chk(`OFS_PORT_DATA, 8'h0D);
  endtask
  task automatic t_capture();
    do_reset();
    wr_reg(`OFS_CHAN_IRQ, 8'h01);
    wr_reg(`OFS_FUNC_SEL, 8'h00);
    wr_reg(`OFS_PORT_DIR, 8'h00);
    wr_reg(`OFS_EDGE_CTL, 8'h01);
    wr_reg(`OFS_SYS_CTL, 8'h01);
    `CHK(pin_oe_n, 4'hF)
    @(posedge clk);
    ext <= 4'h1;
    wait_irq(0);
    rd_chk(`OFS_CHAN_FLAG, 8'h01);
    `CHK(n_cap, 1)
    wr_reg(`OFS_CHAN_FLAG, 8'h00);
    rd_chk(`OFS_CHAN_FLAG, 8'h01);
    wr_reg(`OFS_CHAN_FLAG, 8'h01);
    rd_chk(`OFS_CHAN_FLAG, 8'h00);
    wr_reg(`OFS_PORT_DIR, 8'h01);
    wr_reg(`OFS_PORT_DATA, 8'h01);
    `CHK(pin_out[0], 1'b1)
    wait_irq(0);
    `CHK(irq, 7'h01)
    `CHK(n_cap, 2)
    wr_reg(`OFS_SYS_CTL, 8'h03);
    rd_chk(`OFS_VALUE0, 8'h00);
    `CHK(irq, 7'h00)
    wr_reg(`OFS_EDGE_CTL, 8'h03);
    wr_reg(`OFS_PORT_DATA, 8'h00);
    wait_irq(0);
    `CHK(n_cap, 3)
  endtask
  task automatic t_compare();
    do_reset();
    wr_reg(`OFS_SYS_CTL, 8'h01);
    wr_reg(`OFS_FUNC_SEL, 8'h0F);
    wr_reg(`OFS_PORT_DIR, 8'h00);
    wr_reg(`OFS_OUT_ACT, 8'h0C);
    `CHK(pin_oe_n, 4'hD)
    rd_chk(`OFS_PORT_DIR, 8'h00);
    pulse(4'h2, 1'b0, 1'b0);
    `CHK(pin_out[1], 1'b1)
    rd_chk(`OFS_CHAN_FLAG, 8'h02);
    wr_reg(`OFS_OUT_ACT, 8'h04);
    pulse(4'h2, 1'b0, 1'b0);
    `CHK(pin_out[1], 1'b0)
    wr_reg(`OFS_PORT_DATA, 8'h02);
    `CHK(pin_out[1], 1'b0)
    pulse(4'h1, 1'b0, 1'b0);
    `CHK(pin_oe_n[0], 1'b1)
    rd_chk(`OFS_CHAN_FLAG, 8'h03);
  endtask
  task automatic t_ch3();
    do_reset();
    wr_reg(`OFS_SYS_CTL, 8'h01);
    wr_reg(`OFS_FUNC_SEL, 8'h0E);
    wr_reg(`OFS_CH3_DATA, 8'h05);
    wr_reg(`OFS_CH3_MASK, 8'h05);
    `CHK(pin_oe_n, 4'hB)
    rd_chk(`OFS_PORT_DIR, 8'h00);
    pulse(4'h8, 1'b0, 1'b0);
    `CHK(pin_out[2], 1'b1)
    `CHK(n_ch3, 1)
    wr_reg(`OFS_PORT_DIR, 8'h05);
    rd_chk(`OFS_PORT_DATA, 8'h05);
    wr_reg(`OFS_OUT_ACT, 8'h20);
    pulse(4'h4, 1'b0, 1'b0);
    `CHK(pin_out[2], 1'b0)
  endtask
  task automatic t_flags();
    do_reset();
    wr_reg(`OFS_SYS_CTL, 8'h03);
    wr_reg(`OFS_FUNC_SEL, 8'h0F);
    wr_reg(`OFS_CHAN_IRQ, 8'h0F);
    wr_reg(`OFS_ACC_CTL, 8'h0B);
    wr_reg(`OFS_CNT_IRQ, 8'h01);
    pulse(4'hF, 1'b1, 1'b1);
    @(posedge clk);
    ext <= 4'h8;
    wait_irq(5);
    `CHK(irq, 7'h7F)
    wr_reg(`OFS_VALUE0 + 5'h01, 8'h00);
    `CHK(irq, 7'h7D)
    rd_chk(`OFS_ACC_CNT_LO, 8'h00);
    `CHK(irq, 7'h4D)
    wr_reg(`OFS_CNT_FLAG, 8'h01);
    `CHK(irq, 7'h0D)
    wr_reg(`OFS_CHAN_FLAG, 8'h0D);
    `CHK(irq, 7'h00)
    wr_reg(`OFS_ACC_CTL, 8'h0C);
    `CHK(acc_gate, 1'b1)
    @(posedge clk);
    ext <= 4'h0;
    repeat (8) @(posedge clk);
    `CHK(acc_gate, 1'b0)
    `CHK(n_evt, 1)
    pulse(4'h0, 1'b0, 1'b1);
    rd_chk(`OFS_ACC_FLAG, 8'h03);
    wr_reg(`OFS_ACC_FLAG, 8'h03);
    rd_chk(`OFS_ACC_FLAG, 8'h00);
  endtask

  initial begin
    reset = 1'b1;
    {wr, rd, counter_wrap, accum_wrap} = 4'h0;
    addr = 5'h00;
    wdata = 8'h00;
    compare_match = 4'h0;
    ext = 4'h0;
    n_fail = 0;
    samples_checked = 0;
    t_reset();
    t_gpio();
    t_capture();
    t_compare();
    t_ch3();
    t_flags();
    results();
  end
endmodule // timer_pin_function_and_flags_tb_top
